// ---- rtl/flash_sec_defines.svh ----
`ifndef FLASH_SEC_DEFINES_SVH
`define FLASH_SEC_DEFINES_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_OPTION 12'h000
`define OFF_CONFIG 12'h004
`define OFF_PROT 12'h008
`define OFF_STATUS 12'h00C

// ----------------------------------------
// Option shadow register fields
// ----------------------------------------
`define OPT_MASK 8'hC3
`define OPT_BACKDOOR_ENABLE_BIT 7
`define OPT_NORED_BIT 6
`define OPT_SEC_MSB 1
`define OPT_SEC_LSB 0
`define SEC_UNSECURED 2'h2

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define CFG_MASK 8'hE0
`define CFG_RESET 8'h00
`define CFG_KEY_WRITE_ACCESS_BIT 5

// ----------------------------------------
// Protection shadow register fields
// ----------------------------------------
`define PROT_MASK 8'hF8
`define PROT_OPEN_BIT 7
`define PROT_DIS_BIT 6
`define PROT_FPS_MSB 5
`define PROT_FPS_LSB 3
`define PROT_SIZE_ALL 3'h7
`define PROT_SIZE_32K 3'h5
`define PROT_SIZE_60K 3'h6
`define PROT_BASE_ALL 16'h182C
`define PROT_MIN_BYTES 17'h00200
`define ADDR_TOP 17'h10000

// ----------------------------------------
// Key window and vector area
// ----------------------------------------
`define KEY_ADDR_HI 13'h1FF6
`define KEY_BYTES 4'h8
`define VEC_AREA_HI 10'h3FF
`define VEC_RESET_LO 5'h1F
`define VEC_STEP_DOWN 10'h001

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- rtl/flash_sec_pkg.sv ----
package flash_sec_pkg;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_OPTION = 3'b001,
        SEL_CONFIG = 3'b010,
        SEL_PROT = 3'b011,
        SEL_STATUS = 3'b100
    } reg_sel_t;

    typedef logic [7:0] byte_t;

endpackage

// ---- rtl/key_compare.sv ----
`include "flash_sec_defines.svh"

module key_compare (
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic key_byte_wr, // One key byte offered
    input wire logic [2:0] key_byte_idx, // Offset within key window
    input wire logic [7:0] key_byte_data, // Key byte value
    input wire logic key_check, // Compare now and clear
    input wire logic [63:0] stored_backdoor_key, // First byte in 63:56
    output logic key_match, // One-cycle pulse on a match
    output logic [3:0] key_count // Bytes taken so far
);

    logic [63:0] key_buf;
    logic key_bad;
    wire logic in_order;
    wire logic full;

    // Bytes must arrive at ascending offsets starting at the bottom
    assign in_order = ({1'b0, key_byte_idx} == key_count);
    assign full = (key_count == `KEY_BYTES);

    // ----------------------------------------
    // Capture and compare
    // ----------------------------------------
    // A stray or repeated byte poisons the attempt rather than being
    // dropped, so a partial key can never slide into a match.
    always_ff @(posedge aclk) begin
        if (!aresetn || key_check) begin
            key_buf <= 64'h0000000000000000;
            key_count <= 4'h0;
            key_bad <= 1'b0;
        end else if (key_byte_wr) begin
            if (!full && in_order) begin
                key_buf <= {key_buf[55:0], key_byte_data};
                key_count <= key_count + 4'h1;
            end else begin
                key_bad <= 1'b1;
            end
        end
    end

    // Match only for eight in-order bytes equal to the stored key
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_match <= 1'b0;
        end else begin
            key_match <= key_check && full && !key_bad &&
                (key_buf == stored_backdoor_key);
        end
    end

endmodule

// ---- rtl/flash_security_protection_cfg.sv ----
`include "flash_sec_defines.svh"


module flash_security_protection_cfg #(
    parameter int FLASH_KBYTES = 60, // Flash size variant
    parameter int ADDR_W = 12 // AXI address width
) (
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Synchronous reset, active low
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] awaddr, // Write address
    input wire logic [2:0] awprot, // Unused protection info
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic [2:0] arprot, // Unused protection info
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    // Nonvolatile contents
    input wire logic [7:0] nv_option_byte, // Stored option byte
    input wire logic [7:0] nv_protection_byte, // Stored protection byte
    input wire logic [63:0] stored_backdoor_key, // Key, first in 63:56
    input wire logic blank_check_ok, // Pulse: whole flash erased
    // Background debug write to protection
    input wire logic dbg_prot_wr, // Pulse: debug writes protection
    input wire logic [7:0] dbg_prot_data, // Value for protection
    // Flash array writes from the core or debug
    input wire logic flash_wr, // Pulse: write to flash space
    input wire logic [15:0] flash_wr_addr, // Write address
    input wire logic [7:0] flash_wr_data, // Write data
    input wire logic flash_wr_dbg, // Write issued by debug
    // Memory read/access requests
    input wire logic mem_req, // Pulse: RAM or flash access
    input wire logic mem_req_unsecured, // Source is unsecured
    input wire logic mem_req_flash_rd, // Access is a flash read
    // Vector fetch
    input wire logic vec_req, // Pulse: vector fetch
    input wire logic [15:0] vec_addr, // Vector address
    // Results
    output logic secured, // Device is secured
    output logic cmd_start, // Pulse: command write accepted
    output logic cmd_refused, // Pulse: command write refused
    output logic [15:0] cmd_addr, // Command address
    output logic [7:0] cmd_data, // Command data
    output logic mem_grant, // Pulse: access allowed
    output logic mem_deny, // Pulse: access blocked
    output logic mem_rd_invalid, // Pulse: flash read gives junk
    output logic vec_valid, // Pulse: mapped vector ready
    output logic [15:0] vec_mapped // Mapped vector address
);

    // Only the three size variants with distinct redirection exist
    if (FLASH_KBYTES != 16 && FLASH_KBYTES != 32 &&
        FLASH_KBYTES != 60) begin : g_bad_size
        $error("FLASH_KBYTES must be 16, 32 or 60");
    end
    if (ADDR_W < 4) begin : g_bad_addr
        $error("ADDR_W must be at least 4");
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] option_shadow_reg;
    logic [7:0] config_reg;
    logic [7:0] protection_shadow_reg;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [7:0] w_byte_q;
    logic w_lane0_q;

    // Field views
    wire logic backdoor_enable;
    wire logic redirect_disable;
    wire logic [1:0] security_code;
    wire logic key_write_access;
    wire logic open_for_program;
    wire logic block_protect_off;
    wire logic [2:0] protect_size_sel;

    assign backdoor_enable = option_shadow_reg[`OPT_BACKDOOR_ENABLE_BIT];
    assign redirect_disable = option_shadow_reg[`OPT_NORED_BIT];
    assign security_code =
        option_shadow_reg[`OPT_SEC_MSB:`OPT_SEC_LSB];
    assign key_write_access = config_reg[`CFG_KEY_WRITE_ACCESS_BIT];
    assign open_for_program = protection_shadow_reg[`PROT_OPEN_BIT];
    assign block_protect_off = protection_shadow_reg[`PROT_DIS_BIT];
    assign protect_size_sel =
        protection_shadow_reg[`PROT_FPS_MSB:`PROT_FPS_LSB];

    // Every code but 10 is secure
    wire logic is_secured;
    assign is_secured = (security_code != `SEC_UNSECURED);

    // ----------------------------------------
    // Protected range and redirection
    // ----------------------------------------
    wire logic [16:0] block_bytes;
    wire logic [16:0] pow_base;
    wire logic [15:0] protect_base;
    wire logic protect_active;
    wire logic size_has_redirect;
    wire logic redirect_active;
    wire logic [9:0] redirect_hi;

    // Size doubles from 512 bytes per code step; 111 is nearly all
    assign block_bytes = `PROT_MIN_BYTES << protect_size_sel;
    assign pow_base = `ADDR_TOP - block_bytes;
    assign protect_base = (protect_size_sel == `PROT_SIZE_ALL) ?
        `PROT_BASE_ALL : pow_base[15:0];
    assign protect_active = !block_protect_off;

    // Large blocks only redirect on the bigger variants
    assign size_has_redirect =
        (protect_size_sel == `PROT_SIZE_ALL) ? 1'b0 :
        (protect_size_sel == `PROT_SIZE_60K) ? (FLASH_KBYTES == 60) :
        (protect_size_sel == `PROT_SIZE_32K) ? (FLASH_KBYTES >= 32) :
        1'b1;
    assign redirect_active = open_for_program && protect_active &&
        !redirect_disable && size_has_redirect;
    assign redirect_hi = protect_base[15:6] - `VEC_STEP_DOWN;

    // ----------------------------------------
    // Flash write steering
    // ----------------------------------------
    wire logic in_key_window;
    wire logic key_wr;
    wire logic key_wr_dropped;
    wire logic cmd_wr;
    wire logic cmd_blocked;

    assign in_key_window = (flash_wr_addr[15:3] == `KEY_ADDR_HI);
    // Debug can never feed the comparator, so its writes there are lost while key access is set
    assign key_wr = flash_wr && key_write_access && in_key_window &&
        !flash_wr_dbg;
    assign key_wr_dropped = flash_wr && key_write_access &&
        in_key_window && flash_wr_dbg;
    assign cmd_wr = flash_wr && !key_wr && !key_wr_dropped;
    // Open clear, address in block, or debug while secured all refuse
    assign cmd_blocked = !open_for_program ||
        (protect_active && (flash_wr_addr >= protect_base)) ||
        (flash_wr_dbg && is_secured);

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire logic aw_hs;
    wire logic w_hs;
    wire logic ar_hs;
    wire logic write_fire;
    wire logic next_have_aw;
    wire logic next_have_w;
    wire logic next_bvalid;
    wire logic next_rvalid;
    flash_sec_pkg::reg_sel_t wr_sel;
    flash_sec_pkg::reg_sel_t rd_sel;
    wire logic [7:0] rd_byte;
    wire logic [7:0] status_byte;
    wire logic cfg_wr;
    wire logic key_check;
    wire logic key_match;
    wire logic [3:0] key_count;

    assign aw_hs = awvalid && awready;
    assign w_hs = wvalid && wready;
    assign ar_hs = arvalid && arready;
    assign write_fire = have_aw && have_w && !bvalid;
    assign next_have_aw = write_fire ? 1'b0 : (have_aw || aw_hs);
    assign next_have_w = write_fire ? 1'b0 : (have_w || w_hs);
    assign next_bvalid = write_fire || (bvalid && !bready);
    assign next_rvalid = ar_hs || (rvalid && !rready);

    function automatic flash_sec_pkg::reg_sel_t decode(
        input logic [ADDR_W-1:0] a
    );
        case (a)
            ADDR_W'(`OFF_OPTION): decode = flash_sec_pkg::SEL_OPTION;
            ADDR_W'(`OFF_CONFIG): decode = flash_sec_pkg::SEL_CONFIG;
            ADDR_W'(`OFF_PROT): decode = flash_sec_pkg::SEL_PROT;
            ADDR_W'(`OFF_STATUS): decode = flash_sec_pkg::SEL_STATUS;
            default: decode = flash_sec_pkg::SEL_NONE;
        endcase
    endfunction

    assign wr_sel = decode(aw_addr_q);
    assign rd_sel = decode(araddr);

    // Own status view: secured, key progress, range state
    assign status_byte = {1'b0, protect_active, redirect_active,
        key_count, is_secured};

    assign rd_byte =
        (rd_sel == flash_sec_pkg::SEL_OPTION) ?
            (option_shadow_reg & `OPT_MASK) :
        (rd_sel == flash_sec_pkg::SEL_CONFIG) ?
            (config_reg & `CFG_MASK) :
        (rd_sel == flash_sec_pkg::SEL_PROT) ?
            (protection_shadow_reg & `PROT_MASK) :
        (rd_sel == flash_sec_pkg::SEL_STATUS) ? status_byte : 8'h00;

    // Option and protection sit in no write path from the bus
    assign cfg_wr = write_fire && w_lane0_q &&
        (wr_sel == flash_sec_pkg::SEL_CONFIG);
    // Software dropping key access is what launches the comparison
    assign key_check = cfg_wr && key_write_access &&
        !w_byte_q[`CFG_KEY_WRITE_ACCESS_BIT];

    // ----------------------------------------
    // Key capture and comparison
    // ----------------------------------------
    key_compare u_key (
        .aclk(aclk),
        .aresetn(aresetn),
        .key_byte_wr(key_wr),
        .key_byte_idx(flash_wr_addr[2:0]),
        .key_byte_data(flash_wr_data),
        .key_check(key_check),
        .stored_backdoor_key(stored_backdoor_key),
        .key_match(key_match),
        .key_count(key_count)
    );

    // ----------------------------------------
    // Option shadow
    // ----------------------------------------
    // Reloaded on every reset; afterwards only unlock events touch it,
    // so a new option byte needs a fresh reset to take effect.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            option_shadow_reg <= nv_option_byte & `OPT_MASK;
        end else if ((key_match && backdoor_enable) ||
                     blank_check_ok) begin
            option_shadow_reg[`OPT_SEC_MSB:`OPT_SEC_LSB] <=
                `SEC_UNSECURED;
        end
    end

    // ----------------------------------------
    // Configuration and protection shadow
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            config_reg <= `CFG_RESET;
        end else if (cfg_wr) begin
            config_reg <= w_byte_q & `CFG_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            protection_shadow_reg <=
                nv_protection_byte & `PROT_MASK;
        end else if (dbg_prot_wr) begin
            protection_shadow_reg <=
                dbg_prot_data & `PROT_MASK;
        end
    end

    // ----------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------
    // Address and data are taken in either order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            have_aw <= next_have_aw;
            have_w <= next_have_w;
            awready <= !next_have_aw && !next_bvalid;
            wready <= !next_have_w && !next_bvalid;
            bvalid <= next_bvalid;
            if (write_fire) begin
                bresp <= (wr_sel == flash_sec_pkg::SEL_NONE) ?
                    `RESP_SLVERR : `RESP_OKAY;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_q <= '0;
            w_byte_q <= 8'h00;
            w_lane0_q <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_addr_q <= awaddr;
            end
            if (w_hs) begin
                w_byte_q <= wdata[7:0];
                w_lane0_q <= wstrb[0];
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RESP_OKAY;
        end else begin
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (ar_hs) begin
                rdata <= {24'h000000, rd_byte};
                rresp <= (rd_sel == flash_sec_pkg::SEL_NONE) ?
                    `RESP_SLVERR : `RESP_OKAY;
            end
        end
    end

    // ----------------------------------------
    // Command steering and access control
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_start <= 1'b0;
            cmd_refused <= 1'b0;
            cmd_addr <= 16'h0000;
            cmd_data <= 8'h00;
        end else begin
            cmd_start <= cmd_wr && !cmd_blocked;
            cmd_refused <= cmd_wr && cmd_blocked;
            if (cmd_wr) begin
                cmd_addr <= flash_wr_addr;
                cmd_data <= flash_wr_data;
            end
        end
    end

    // Flash read data is junk while key access is set, whatever the source
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            secured <= 1'b1;
            mem_grant <= 1'b0;
            mem_deny <= 1'b0;
            mem_rd_invalid <= 1'b0;
        end else begin
            secured <= is_secured;
            mem_deny <= mem_req && is_secured &&
                mem_req_unsecured;
            mem_grant <= mem_req &&
                !(is_secured && mem_req_unsecured);
            mem_rd_invalid <= mem_req && mem_req_flash_rd &&
                key_write_access;
        end
    end

    // ----------------------------------------
    // Vector mapping
    // ----------------------------------------
    wire logic vec_in_area;
    wire logic vec_is_reset;

    assign vec_in_area = (vec_addr[15:6] == `VEC_AREA_HI);
    assign vec_is_reset = (vec_addr[5:1] == `VEC_RESET_LO);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vec_valid <= 1'b0;
            vec_mapped <= 16'h0000;
        end else begin
            vec_valid <= vec_req;
            if (vec_req) begin
                if (redirect_active && vec_in_area &&
                    !vec_is_reset) begin
                    vec_mapped <= {redirect_hi, vec_addr[5:0]};
                end else begin
                    vec_mapped <= vec_addr;
                end
            end
        end
    end

endmodule

// ---- sim/flash_sec_monitor.sv ----
module flash_sec_monitor (
    input wire logic aclk, // Bus clock
    input wire logic aresetn, // Reset, active low
    input wire logic bvalid, // Write answer valid
    input wire logic bready, // Write answer taken
    input wire logic [1:0] bresp, // Write answer code
    input wire logic rvalid, // Read answer valid
    input wire logic [31:0] rdata, // Read data
    input wire logic flash_wr, // Flash write pulse
    input wire logic flash_wr_dbg, // Write from debug
    input wire logic secured, // Security state
    input wire logic cmd_start, // Command accepted
    input wire logic cmd_refused, // Command refused
    input wire logic mem_req, // Access request
    input wire logic mem_req_unsecured, // Untrusted source
    input wire logic mem_grant, // Access allowed
    input wire logic mem_deny, // Access blocked
    input wire logic vec_req, // Vector fetch
    input wire logic [15:0] vec_addr, // Fetched vector
    input wire logic vec_valid, // Vector answer
    input wire logic [15:0] vec_mapped // Answered vector
);
    // ----------------------------------------
    // Port relations
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Answers only follow a request, one cycle later
    a_cmd_cause: assert property (
        (cmd_start || cmd_refused) |-> $past(flash_wr))
        else $error("command pulse without a write");
    a_cmd_onehot: assert property (!(cmd_start && cmd_refused))
        else $error("command both started and refused");
    a_dbg_no_cmd: assert property (
        flash_wr && flash_wr_dbg && secured |=> !cmd_start)
        else $error("debug command ran while secured");
    a_mem_answer: assert property (
        mem_req |=> mem_grant != mem_deny)
        else $error("access answer not exclusive");
    // Reset value of secured is stale on the first edge, hence the guard
    a_unsec_deny: assert property (
        mem_req && mem_req_unsecured && secured && $past(aresetn)
        |=> mem_deny)
        else $error("untrusted access not blocked");
    a_vec_answer: assert property (vec_req |=> vec_valid)
        else $error("vector fetch not answered");
    a_reset_vec_kept: assert property (
        vec_req && vec_addr[15:1] == 15'h7FFF
        |=> vec_mapped == $past(vec_addr))
        else $error("reset vector moved");
    a_rdata_upper: assert property (
        rvalid |-> rdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    a_bresp_hold: assert property (
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    c_refused: cover property (cmd_refused);
    c_denied: cover property (mem_deny);
    c_unsecured: cover property ($fell(secured));
endmodule

// ---- sim/flash_security_protection_cfg_test.sv ----
`include "flash_sec_defines.svh"

module flash_security_protection_cfg_test;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [11:0] a; logic wr; logic [7:0] d, q;
        logic [1:0] resp;} row_t;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0, dbg_prot_wr = 1'b0;
    logic blank_check_ok = 1'b0, flash_wr = 1'b0, flash_wr_dbg = 1'b0;
    logic mem_req = 1'b0, vec_req = 1'b0;
    logic mem_req_unsecured = 1'b0, mem_req_flash_rd = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [7:0] nv_option_byte = 8'hBD, nv_protection_byte = 8'h87;
    logic [7:0] dbg_prot_data = 8'h00, flash_wr_data = 8'h00, cmd_data;
    logic [63:0] stored_backdoor_key = 64'h0123456789ABCDEF;
    logic [15:0] flash_wr_addr = 16'h0000, vec_addr = 16'h0000;
    logic [15:0] cmd_addr, vec_mapped;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, secured, cmd_start;
    logic cmd_refused, mem_grant, mem_deny, mem_rd_invalid, vec_valid;
    int err_total = 0, compares = 0;
    // Register reset values, write-ignored places and an unmapped word
    row_t rows [6] = '{'{12'h004, 1'b0, 8'h00, 8'h00, 2'h0},
    '{12'h000, 1'b1, 8'hFF, 8'h81, 2'h0}, '{12'h008, 1'b1, 8'h00, 8'h80, 2'h0},
    '{12'h004, 1'b1, 8'hFF, 8'hE0, 2'h0}, '{12'h004, 1'b1, 8'h00, 8'h00, 2'h0},
    '{12'h010, 1'b0, 8'h00, 8'h00, 2'h2}};

    flash_security_protection_cfg #(.FLASH_KBYTES(60), .ADDR_W(12))
        i_flash_security_protection_cfg (.*);

    // ----------------------------------------
    // Clock, checks and bus tasks
    // ----------------------------------------
    initial begin
        forever #12.5 aclk = ~aclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Handshakes are judged on pre-edge values, as the slave sees them
    // Answer ready stays high, so it is never dropped and raised at once
    task automatic axw(input logic [11:0] a, input logic [7:0] d,
        output logic [1:0] r);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    task automatic fw(input logic [15:0] a, input logic [7:0] d,
        input logic dbg, input logic [1:0] e);
        flash_wr <= 1'b1;
        flash_wr_addr <= a;
        flash_wr_data <= d;
        flash_wr_dbg <= dbg;
        @(posedge aclk);
        flash_wr <= 1'b0;
        @(posedge aclk);
        chk({cmd_start, cmd_refused}, e);
    endtask

    task automatic mem(input logic u, input logic f, input logic [2:0] e);
        mem_req <= 1'b1;
        mem_req_unsecured <= u;
        mem_req_flash_rd <= f;
        @(posedge aclk);
        mem_req <= 1'b0;
        @(posedge aclk);
        chk({mem_grant, mem_deny, mem_rd_invalid}, e);
    endtask

    task automatic vec(input logic [15:0] a, input logic [15:0] e);
        vec_req <= 1'b1;
        vec_addr <= a;
        @(posedge aclk);
        vec_req <= 1'b0;
        @(posedge aclk);
        chk({vec_valid, vec_mapped}, {1'b1, e});
    endtask

    task automatic dbgp(input logic [7:0] d);
        dbg_prot_wr <= 1'b1;
        dbg_prot_data <= d;
        @(posedge aclk);
        dbg_prot_wr <= 1'b0;
    endtask

    // Key bytes in ascending order, then clearing key access compares them
    task automatic key_try(input logic [7:0] e);
        logic [1:0] r;
        logic [31:0] d;
        axw(12'h004, 8'h20, r);
        mem(1'b0, 1'b1, 3'b101);
        fw(16'hFFB0, 8'h00, 1'b1, 2'b00);
        for (int i = 0; i < 8; i++)
            fw(16'hFFB0 + 16'(i), stored_backdoor_key[63-8*i -: 8], 1'b0,
                2'b00);
        axw(12'h004, 8'h00, r);
        axr(12'h000, d, r);
        chk(d, {24'h000000, e});
        chk(secured, e[1:0] != 2'b10);
        $display("test backdoor key done");
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        logic [1:0] r;
        logic [31:0] d;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axw(rows[i].a, rows[i].d, r);
                chk(r, `RESP_OKAY);
            end
            axr(rows[i].a, d, r);
            chk(d, {24'h0, rows[i].q});
            chk(r, rows[i].resp);
        end
        $display("test registers done");
        fw(16'hFE10, 8'h00, 1'b0, 2'b01);
        fw(16'hFDFF, 8'h00, 1'b0, 2'b10);
        chk({cmd_addr, cmd_data}, 24'hFDFF00);
        fw(16'hFDFF, 8'h00, 1'b1, 2'b01);
        mem(1'b1, 1'b0, 3'b010);
        vec(16'hFFC4, 16'hFDC4);
        vec(16'hFFFE, 16'hFFFE);
        dbgp(8'hB0);
        vec(16'hFFC4, 16'h7FC4);
        dbgp(8'hB8);
        vec(16'hFFC4, 16'hFFC4);
        fw(16'h182C, 8'h00, 1'b0, 2'b01);
        fw(16'h182B, 8'h00, 1'b0, 2'b10);
        dbgp(8'h00);
        fw(16'h1000, 8'h00, 1'b0, 2'b01);
        axr(12'h008, d, r);
        chk(d, 32'h00000000);
        dbgp(8'hC0);
        fw(16'hFE10, 8'h00, 1'b0, 2'b10);
        $display("test protection done");
        key_try(8'h82);
        mem(1'b1, 1'b0, 3'b100);
        // Fresh reset with key enable clear: new option byte must take hold
        aresetn <= 1'b0;
        nv_option_byte <= 8'h7D;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(12'h008, d, r);
        chk(d, 32'h00000080);
        vec(16'hFFC4, 16'hFFC4);
        key_try(8'h41);
        blank_check_ok <= 1'b1;
        @(posedge aclk);
        blank_check_ok <= 1'b0;
        repeat (2) @(posedge aclk);
        chk(secured, 1'b0);
        results();
    end

    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        results();
    end
endmodule

bind flash_security_protection_cfg flash_sec_monitor i_flash_sec_monitor (.*);
